// ===== rtl/sft_pkg.sv
/*
 * Constants, carrier types and state layout of the SENT frame
 * transmitter.
 * Assumes one 20 MHz clock domain and a 32-bit APB register bus.
 */
package sft_pkg;

  // ****************************************
  // Clock and tick timing
  // ****************************************
  localparam int          CLK_NS   = 50;    // 20 MHz clock period
  localparam int          TICK_NS  = 5000;  // Default tick of 5 us
  localparam logic [15:0] TICK_CYC = 16'(TICK_NS / CLK_NS);

  // ****************************************
  // Segment and message lengths in ticks, test frame counts, last nibble index
  // ****************************************
  localparam logic [8:0] SYNC_TK      = 9'h038;  // 56
  localparam logic [8:0] NIB_BASE_TK  = 9'h00c;  // 12
  localparam logic [8:0] LOW_TK       = 9'h005;
  localparam logic [8:0] PAUSE_LOW_TK = 9'h00c;  // 12
  localparam logic [8:0] PAUSE_PER_TK = 9'h100;  // 256
  localparam logic [8:0] PAUSE_MIN_TK = 9'h00d;
  localparam logic [8:0] RESUME_TK    = 9'h00c;  // 12
  localparam logic [8:0] MSG_MIN_TK   = 9'h09a;  // 154
  localparam logic [8:0] MSG_MAX_TK   = 9'h10e;  // 270
  localparam logic [4:0] COIL_SELF_TEST_MSGS    = 5'h08;
  localparam logic [4:0] COIL_SELF_TEST_TOTAL   = 5'h10;
  localparam logic [2:0] LAST_NIB     = 3'h7;

  // ****************************************
  // Checksum and status codes
  // ****************************************
  localparam logic [3:0] CRC_SEED    = 4'h5;
  localparam logic [3:0] CRC_POLY    = 4'hd;  // x4+x3+x2+1, top dropped
  localparam logic [1:0] ST_NORMAL   = 2'h0;
  localparam logic [1:0] ST_ERROR    = 2'h1;
  localparam logic [1:0] ST_COIL_SELF_TEST_POS = 2'h2;
  localparam logic [1:0] ST_COIL_SELF_TEST_NEG = 2'h3;

  // ****************************************
  // Register map
  // ****************************************
  localparam int         ADDR_W      = 8;
  localparam int         TICK_W      = 16;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TICK   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FIELD  = 8'h0c;

  typedef struct packed {
    logic line_coil_self_test_en;
    logic pin_coil_self_test_en;
    logic range_wide;
    logic pause_en;
  } sft_ctrl_t;
  localparam int        CTRL_W   = $bits(sft_ctrl_t);
  localparam sft_ctrl_t CTRL_RST = 4'h8;

  typedef struct packed {
    logic [12:0] rsvd;
    logic        drv;
    logic [1:0]  stat;
    logic [7:0]  cnt;
    logic [4:0]  bistn;
    logic        neg;
    logic        coil;
    logic        sleep;
  } sft_stat_t;

  // ****************************************
  // Sequencer state
  // ****************************************
  typedef enum logic [2:0] {
    S_SLEEP, S_SYNC, S_NIB, S_PAUSE, S_HOLD, S_RESUME
  } sft_state_t;

  typedef struct packed {
    sft_state_t  state;
    logic [15:0] div;
    logic [8:0]  seg;
    logic [8:0]  len;
    logic [2:0]  nib;
    logic [8:0]  ftk;
    logic [8:0]  lowc;
    logic [11:0] smp;
    logic [11:0] fld;
    logic [1:0]  stat;
    logic [7:0]  cnt;
    logic [4:0]  bistn;
    logic        pinon;
    logic        pol;
    logic        coil;
    logic        cpol;
    logic        drv;
    logic        conv;
    logic [1:0]  s_line;
    logic [1:0]  s_pin;
    logic [1:0]  s_slp;
    sft_ctrl_t   ctrl;
    logic [15:0] tdiv;
    logic [31:0] prdata;
    logic        perr;
  } sft_st_t;

  localparam sft_st_t ST_RST = '{state: S_SLEEP, tdiv: TICK_CYC,
    ctrl: CTRL_RST, s_line: 2'h3, s_pin: 2'h3, s_slp: 2'h3,
    default: '0};

endpackage

// ===== rtl/sft_crc.sv
/*
 * CRC nibble over the six data nibbles of one frame.
 * Assumes the caller holds the data steady for the whole frame.
 */
`timescale 1ns/1ps
module sft_crc (
  // Six data nibbles, first sent in the top bits
  input  wire logic [23:0] data_in,
  // Checksum nibble
  output logic      [3:0]  crc_out
);
  import sft_pkg::*;

  // Bitwise division, augmented by one zero nibble
  always_comb begin
    logic [3:0]  c;
    logic [27:0] bits;
    c    = CRC_SEED;
    bits = {data_in, 4'h0};
    for (int i = 27; i >= 0; i--) begin
      c = c[3] ? ({c[2:0], bits[i]} ^ CRC_POLY) : {c[2:0], bits[i]};
    end
    crc_out = c;
  end

endmodule // sft_crc

// ===== rtl/sft_top.sv
/*
 * SENT frame transmitter: sync, status, six data nibbles, CRC and an
 * optional pause on one open-drain line, plus self-test and sleep.
 * Assumes the field converter and APB master share CLK_IN; the line,
 * self-test and sleep pins are asynchronous.
 */
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// Function
// [R1] Status top two bits always zero
// [R2] Status low bits: normal, error, positive, negative
// [R3] Nibbles 1-3 carry field, MSB first
// [R4] Nibbles 4-5 carry rolling counter, upper first
// [R5] Nibble 6 inverts nibble 1
// [R6] Field word unsigned, 2048 is zero
// [R7] Full-scale range selectable, narrow or wide
// [R8] CRC seed 0101, poly x4+x3+x2+1
// [R9] Optional pause, 12 low in 256
// [R10] Message without pause lasts 154 to 270
// [R11] Default 5 us tick, about 1 ms
// [R12] Conversion starts with sync, reported that frame
// [R13] Receiver holds line low one message
// [R14] Resume 12 ticks after line high
// [R15] Eight positive then eight negative test frames
// [R16] Test pin low energises coil
// [R17] Each pin activation reverses coil polarity
// [R18] Sleep while sleep pin high
// [R19] Host checks field change during test
// [R20] Sync period lasts 56 ticks
// [R21] Eight nibbles: status, six data, CRC
// [R22] Segments delimited by falling edges
// [R23] Nibble value v spans 12+v ticks
// [R24] Each segment starts five ticks low; the pause segment here starts twelve ticks low
// [R25] Rolling counter increments per message, wraps
// [R26] CRC over data nibbles only, reseeded
module sft_top (
  // Clock and reset
  input  wire logic                       CLK_IN,
  input  wire logic                       RESETN_IN,
  // APB slave
  input  wire logic                       PSEL_IN,
  input  wire logic                       PENABLE_IN,
  input  wire logic                       PWRITE_IN,
  input  wire logic [sft_pkg::ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]                PWDATA_IN,
  output logic      [31:0]                PRDATA_OUT,
  output logic                            PREADY_OUT,
  output logic                            PSLVERR_OUT,
  // Field converter
  input  wire logic [11:0]                FIELD_IN,
  input  wire logic                       FIELD_VALID_IN,
  input  wire logic                       ERROR_IN,
  output logic                            CONV_START_OUT,
  output logic                            RANGE_WIDE_OUT,
  // Open-drain output line
  input  wire logic                       SENSOR_OUTPUT_LINE_IN,
  output logic                            SENSOR_OUTPUT_LINE_OUT,
  output logic                            SENSOR_OUTPUT_LINE_OE_OUT,
  // Self-test and sleep pins
  input  wire logic                       SELF_TEST_REQUEST_N_IN,
  input  wire logic                       SLEEP_REQUEST_IN,
  // Coil and power control
  output logic                            COIL_SELF_TEST_OUT,
  output logic                            COIL_NEG_OUT,
  output logic                            SLEEP_OUT
);
  import sft_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  sft_st_t    r;
  sft_st_t    n;
  sft_stat_t  stw;
  logic       tick_w;
  logic       seg_end_w;
  logic       in_frame_w;
  logic       frame_end_w;
  logic       go;
  logic [3:0] nv_w;
  logic [3:0] crc_w;
  logic [8:0] low_w;
  logic [8:0] ftk1_w;
  logic [1:0] nst_w;
  logic [31:0] rd_w;
  logic       rd_hit_w;
  logic       ro_w;

  // Nibble value by position within the frame
  function automatic logic [3:0] nib_val(input logic [2:0] idx,
                                         input sft_st_t    s,
                                         input logic [3:0] crc);
    unique case (idx)
      3'h0: nib_val = {2'b00, s.stat};  // see [R1]
      3'h1: nib_val = s.fld[11:8];      // see [R3]
      3'h2: nib_val = s.fld[7:4];       // see [R3]
      3'h3: nib_val = s.fld[3:0];       // see [R3]
      3'h4: nib_val = s.cnt[7:4];       // see [R4]
      3'h5: nib_val = s.cnt[3:0];       // see [R4]
      3'h6: nib_val = ~s.fld[11:8];     // see [R5]
      3'h7: nib_val = crc;              // see [R21]
    endcase
  endfunction

  // ****************************************
  // Checksum
  // ****************************************
  // Data nibbles only, status excluded; reseeded every frame
  sft_crc u_crc (
    .data_in ({r.fld, r.cnt, ~r.fld[11:8]}),  // see [R26] [R8]
    .crc_out (crc_w)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Tick prescaler end; 100 cycles by default, frames near 1 ms
  assign tick_w     = (r.div >= r.tdiv - 16'h0001);  // see [R11]
  assign seg_end_w  = tick_w && (r.seg + 9'h001 == r.len);
  assign in_frame_w = r.state inside {S_SYNC, S_NIB, S_PAUSE};
  assign nv_w       = nib_val(r.nib, r, crc_w);
  assign low_w      = (r.state == S_PAUSE) ? PAUSE_LOW_TK : LOW_TK;
  assign ftk1_w     = r.ftk + 9'h001;
  assign frame_end_w = seg_end_w && ((r.state == S_PAUSE) ||
    (r.state == S_NIB && r.nib == LAST_NIB && !r.ctrl.pause_en));

  // Status code for the frame being opened; test wins over error
  always_comb begin
    if (r.bistn > COIL_SELF_TEST_MSGS) begin
      nst_w = ST_COIL_SELF_TEST_POS;                     // see [R2] [R15]
    end else if (r.bistn != 5'h00) begin
      nst_w = ST_COIL_SELF_TEST_NEG;                     // see [R2] [R15]
    end else if (r.pinon) begin
      nst_w = r.pol ? ST_COIL_SELF_TEST_NEG : ST_COIL_SELF_TEST_POS;  // see [R2]
    end else if (ERROR_IN) begin
      nst_w = ST_ERROR;                        // see [R2]
    end else begin
      nst_w = ST_NORMAL;                       // see [R2]
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n      = r;
    go     = 1'b0;
    n.conv = 1'b0;
    // Two-flop synchronisers for the pins
    n.s_line = {r.s_line[0], SENSOR_OUTPUT_LINE_IN};
    n.s_pin  = {r.s_pin[0], SELF_TEST_REQUEST_N_IN};
    n.s_slp  = {r.s_slp[0], SLEEP_REQUEST_IN};
    n.div    = tick_w ? 16'h0000 : r.div + 16'h0001;
    // Prescaler waits in sleep, so the first sync gets full ticks
    if (r.state == S_SLEEP) begin
      n.div = 16'h0000;                        // see [R20]
    end
    // Latest conversion result inside the sync period
    if (r.state == S_SYNC && FIELD_VALID_IN) begin
      n.smp = FIELD_IN;                        // see [R12] [R6]
    end
    // Count ticks with the line seen low, saturating
    if (tick_w) begin
      if (r.s_line[1]) begin
        n.lowc = 9'h000;
      end else if (r.lowc != MSG_MAX_TK) begin
        n.lowc = r.lowc + 9'h001;
      end
    end
    // Coil follows the test pin; polarity flips on release
    n.pinon = r.ctrl.pin_coil_self_test_en && !r.s_pin[1];  // see [R16]
    if (r.pinon && !n.pinon) begin
      n.pol = ~r.pol;                          // see [R17]
    end
    // Segment and frame tick counters
    if (in_frame_w && tick_w) begin
      n.seg = r.seg + 9'h001;
      n.ftk = r.ftk + 9'h001;
    end
    unique case (r.state)
      S_SLEEP: begin
        go = !r.s_slp[1];                      // see [R18]
      end
      S_SYNC: begin
        if (seg_end_w) begin
          n.state = S_NIB;
          n.seg   = 9'h000;
          n.nib   = 3'h0;
          n.fld   = r.smp;                     // see [R12]
          n.stat  = nst_w;
          n.len   = NIB_BASE_TK + {7'h00, nst_w};  // see [R23]
        end
      end
      S_NIB: begin
        if (seg_end_w) begin
          n.seg = 9'h000;
          if (r.nib != LAST_NIB) begin
            n.nib = r.nib + 3'h1;              // see [R21]
            n.len = NIB_BASE_TK +
                    {5'h00, nib_val(r.nib + 3'h1, r, crc_w)};  // see [R23]
          end else if (r.ctrl.pause_en) begin
            n.state = S_PAUSE;                 // see [R9]
            n.len   = (ftk1_w + PAUSE_MIN_TK <= PAUSE_PER_TK) ?
                      PAUSE_PER_TK - ftk1_w : PAUSE_MIN_TK;
          end
        end
      end
      S_PAUSE: begin
        n.seg = (seg_end_w) ? 9'h000 : n.seg;
      end
      S_HOLD: begin
        // Receiver released the line; wait before resuming
        if (tick_w && r.s_line[1]) begin
          n.state = S_RESUME;                  // see [R14]
          n.seg   = 9'h000;
          n.len   = RESUME_TK;
        end
      end
      S_RESUME: begin
        if (tick_w) begin
          n.seg = r.seg + 9'h001;
        end
        if (seg_end_w) begin
          n.bistn = COIL_SELF_TEST_TOTAL;                // see [R15]
          go      = 1'b1;
        end
      end
    endcase
    // Message done: count it and open the next one
    if (frame_end_w) begin
      n.cnt = r.cnt + 8'h01;                   // see [R25]
      if (r.bistn != 5'h00) begin
        n.bistn = r.bistn - 5'h01;             // see [R15]
      end
      go = 1'b1;
    end
    // Open a frame with its sync period and a conversion start
    if (go) begin
      n.state = S_SYNC;                        // see [R20]
      n.seg   = 9'h000;
      n.len   = SYNC_TK;
      n.ftk   = 9'h000;
      n.conv  = 1'b1;                          // see [R12]
    end
    // Line held low for a whole message starts the test
    if (r.ctrl.line_coil_self_test_en && in_frame_w && r.lowc == MSG_MAX_TK) begin
      n.state = S_HOLD;                        // see [R13] [R14]
    end
    // Sleep pin wins over everything else
    if (r.s_slp[1]) begin
      n.state = S_SLEEP;                       // see [R18]
    end
    // Falling edge opens every segment, low for its first ticks
    n.drv = (n.state inside {S_SYNC, S_NIB}) && (n.seg < LOW_TK) ||
            (n.state == S_PAUSE) && (n.seg < PAUSE_LOW_TK);  // see [R22] [R24]
    // Coil drive and polarity
    n.coil = (n.bistn != 5'h00) || n.pinon;    // see [R15] [R16]
    n.cpol = (n.bistn != 5'h00) ? (n.bistn <= COIL_SELF_TEST_MSGS) : n.pol;
    // APB setup cycle: capture read data and the error answer
    if (PSEL_IN && !PENABLE_IN) begin
      n.prdata = rd_w;
      n.perr   = !rd_hit_w || (PWRITE_IN && ro_w);
    end
    // APB access cycle: writes land here
    if (PSEL_IN && PENABLE_IN && PWRITE_IN) begin
      if (PADDR_IN == ADDR_CTRL) begin
        n.ctrl = sft_ctrl_t'(PWDATA_IN[CTRL_W-1:0]);  // see [R7] [R9]
      end
      if (PADDR_IN == ADDR_TICK) begin
        n.tdiv = PWDATA_IN[TICK_W-1:0];
      end
    end
  end

  // ****************************************
  // Register read decode
  // ****************************************
  always_comb begin
    stw = '{rsvd: 13'h0000, drv: r.drv, stat: r.stat, cnt: r.cnt,
           bistn: r.bistn, neg: r.cpol, coil: r.coil,
           sleep: (r.state == S_SLEEP)};
    rd_w     = 32'h0000_0000;
    rd_hit_w = 1'b1;
    ro_w     = 1'b0;
    case (PADDR_IN)
      ADDR_CTRL:   rd_w = {28'h000_0000, r.ctrl};
      ADDR_TICK:   rd_w = {16'h0000, r.tdiv};
      ADDR_STATUS: begin
        rd_w = stw;
        ro_w = 1'b1;
      end
      ADDR_FIELD: begin
        rd_w = {20'h0_0000, r.fld};
        ro_w = 1'b1;
      end
      default:     rd_hit_w = 1'b0;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign PRDATA_OUT                = r.prdata;
  assign PREADY_OUT                = 1'b1;
  assign PSLVERR_OUT               = r.perr;
  assign CONV_START_OUT            = r.conv;
  assign RANGE_WIDE_OUT            = r.ctrl.range_wide;  // see [R7]
  assign SENSOR_OUTPUT_LINE_OUT    = 1'b0;
  assign SENSOR_OUTPUT_LINE_OE_OUT = r.drv;
  assign COIL_SELF_TEST_OUT        = r.coil;
  assign COIL_NEG_OUT              = r.cpol;
  assign SLEEP_OUT                 = (r.state == S_SLEEP);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_line_back;
    r.state == S_HOLD && tick_w && r.s_line[1] && !r.s_slp[1];
  endsequence
  sequence s_resume_end;
    r.state == S_RESUME && seg_end_w;
  endsequence

  property p_stat_top;
    (r.state == S_NIB && r.nib == 3'h0) |-> nv_w[3:2] == 2'b00;
  endproperty
  a_stat_top: assert property (p_stat_top) // see [R1]
    else $error("status nibble top bits not zero");

  property p_coil_self_test_code;
    (r.state == S_SYNC && seg_end_w && r.bistn > COIL_SELF_TEST_MSGS)
      |=> r.stat == ST_COIL_SELF_TEST_POS;
  endproperty
  a_coil_self_test_code: assert property (p_coil_self_test_code) // see [R2]
    else $error("positive test frame without its status code");

  property p_inv_nib;
    (r.state == S_NIB && r.nib == 3'h6) |-> nv_w == ~r.fld[11:8];
  endproperty
  a_inv_nib: assert property (p_inv_nib) // see [R5]
    else $error("sixth nibble is not the inverted first");

  property p_nib_len;
    r.state == S_NIB |-> r.len == NIB_BASE_TK + {5'h00, nv_w};
  endproperty
  a_nib_len: assert property (p_nib_len) // see [R23]
    else $error("nibble period does not match its value");

  property p_drive_win;
    r.drv |-> in_frame_w && r.seg < low_w;
  endproperty
  a_drive_win: assert property (p_drive_win) // see [R24]
    else $error("line driven low outside the segment start");

  property p_seg_edge;
    (seg_end_w && in_frame_w && !r.s_slp[1] && r.lowc != MSG_MAX_TK)
      |=> r.drv && r.seg == 9'h000;
  endproperty
  a_seg_edge: assert property (p_seg_edge) // see [R22]
    else $error("segment not opened by a falling edge");

  property p_msg_len;
    (frame_end_w && r.state == S_NIB)
      |-> ftk1_w >= MSG_MIN_TK && ftk1_w <= MSG_MAX_TK;
  endproperty
  a_msg_len: assert property (p_msg_len) // see [R10]
    else $error("message length outside 154 to 270 ticks");

  property p_cnt_step;
    frame_end_w |=> r.cnt == $past(r.cnt) + 8'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step) // see [R25]
    else $error("rolling counter did not step");

  property p_resume;
    s_line_back |=> r.state == S_RESUME && r.len == RESUME_TK && !r.drv;
  endproperty
  a_resume: assert property (p_resume) // see [R14]
    else $error("no 12 tick wait after line release");

  property p_coil_self_test_load;
    s_resume_end |=> r.bistn == COIL_SELF_TEST_TOTAL && r.conv && r.coil;
  endproperty
  a_coil_self_test_load: assert property (p_coil_self_test_load) // see [R15]
    else $error("self-test frames not loaded after resume");

  property p_sleep;
    r.s_slp[1] |=> r.state == S_SLEEP && !r.drv;
  endproperty
  a_sleep: assert property (p_sleep) // see [R18]
    else $error("not asleep while sleep pin high");

  property p_pol_flip;
    $fell(r.pinon) |-> r.pol != $past(r.pol);
  endproperty
  a_pol_flip: assert property (p_pol_flip) // see [R17]
    else $error("coil polarity not reversed after activation");

endmodule // sft_top

// ===== dv/sft_rx_model.sv
/* Behavioural SENT receiver that decodes the pulled-up output line.
   Assumes the line is sampled on the bench clock, TICK cycles a tick. */
`timescale 1ns/1ps
module sft_rx_model #(
  parameter int TICK = 4
) (
  // Line side
  input  wire logic   clk_in,
  input  wire logic   line_in,
  input  wire logic   hold_in,
  output logic        pull_out,
  // Decoded results
  output logic [31:0] nibs_out,
  output logic [15:0] frames_out,
  output logic [8:0]  len_out,
  output logic [7:0]  low_bad_out
);
  // ****************************************
  // Edge timing decoder
  // ****************************************
  logic        prev = 1'b1;
  logic [31:0] sh;
  int          per = 0, lo = 0, plo = 0, idx = 8, acc = 0, tk;
  // Holding the line low for a whole message asks for a self-test
  assign pull_out = hold_in;  // Request
  // Counters start clear
  initial begin
    frames_out = '0;
    low_bad_out = '0;
  end
  // Segments run from one falling edge to the next
  always @(posedge clk_in) begin
    per++;
    if (!line_in) lo++;
    if (line_in && !prev) begin
      // Long lows are self-test holds, not pulses
      if (lo <= 30 * TICK && lo != 5 * TICK && lo != 12 * TICK)
        low_bad_out <= low_bad_out + 8'h01;  // Low pulse
      plo = lo;
      lo = 0;
    end
    if (!line_in && prev) begin
      tk = (per + TICK / 2) / TICK;  // Edge to edge
      // A pause starts with a long low, so it never passes for sync
      if (tk == 56 && plo < 8 * TICK) begin
        len_out <= 9'(acc);
        acc = 56;
        idx = 0;
      end else begin
        acc += tk;
        if (tk > 27) idx = 8;
        else if (idx < 8) begin
          sh = {sh[27:0], 4'(tk - 12)};  // Nibble value
          idx++;
          if (idx == 8) begin
            nibs_out <= sh;
            frames_out <= frames_out + 16'h0001;
          end
        end
      end
      per = 0;
    end
    prev = line_in;
  end
endmodule  // sft_rx_model

// ===== dv/test_sft_top.sv
/* Self-checking bench of the SENT frame transmitter.
   Assumes sft_rx_model on the line with a tick of 4 clock cycles. */
`timescale 1ns/1ps
module test_sft_top;
  import sft_pkg::*;
  // ****************************************
  // Wiring, clock and helpers
  // ****************************************
  logic        clk, rstn, psel, pen, pwr, fv, err, tst_n, slp, hold;
  logic        prdy, perr, conv, wide, od, oe, coil, neg, sleep, pull, e;
  logic [7:0]  pa, lowbad, last_cnt;
  logic [11:0] fld;
  logic [31:0] pwd, prd, rd, nibs;
  logic [15:0] frames;
  logic [8:0]  len;
  wire         line;
  int          bad_count = 0;
  int          n_checks = 0;
  // Open-drain line with pull-up
  assign line = !((oe && !od) || pull);
  sft_top dut (
    .CLK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .FIELD_IN(fld),
    .FIELD_VALID_IN(fv), .ERROR_IN(err), .CONV_START_OUT(conv),
    .RANGE_WIDE_OUT(wide), .SENSOR_OUTPUT_LINE_IN(line),
    .SENSOR_OUTPUT_LINE_OUT(od), .SENSOR_OUTPUT_LINE_OE_OUT(oe),
    .SELF_TEST_REQUEST_N_IN(tst_n), .SLEEP_REQUEST_IN(slp),
    .COIL_SELF_TEST_OUT(coil), .COIL_NEG_OUT(neg), .SLEEP_OUT(sleep));
  sft_rx_model #(.TICK(4)) rx (
    .clk_in(clk), .line_in(line), .hold_in(hold), .pull_out(pull),
    .nibs_out(nibs), .frames_out(frames), .len_out(len),
    .low_bad_out(lowbad));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // A wait that ran out ends the run
  task automatic hang();
    bad_count++;
    $display("FAIL %0t wait ran out", $time);
    close_out();
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    rd = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (i >= 20) hang();
  endtask
  // Bounded waits for a frame start and a decoded frame
  task automatic wait_conv();
    int i;
    for (i = 0; i < 3000 && conv !== 1'b1; i++) @(posedge clk);
    if (i >= 3000) hang();
  endtask
  task automatic wait_frame();
    logic [15:0] f;
    int          i;
    f = frames;
    for (i = 0; i < 3000 && frames === f; i++) @(posedge clk);
    if (i >= 3000) hang();
  endtask
  // Checksum: seed, six data nibbles, then a zero nibble
  function automatic logic [3:0] crc6(input logic [23:0] d);
    logic [3:0] c;
    logic       f;
    c = 4'h5;
    for (int k = 27; k >= 0; k--) begin
      f = c[3];
      c = {c[2:0], (k > 3) ? d[k-4] : 1'b0};
      if (f) c = c ^ 4'hd;
    end
    return c;
  endfunction
  // Next frame; counter nibbles compared only when cont is set, the rest always
  task automatic chk_frame(input logic [11:0] f, input logic [1:0] st,
                           input logic cont);
    wait_frame();
    check(32'(nibs[31:28]), 32'(st));  // Status
    check(32'(nibs[27:16]), 32'(f));  // Field
    if (cont) check(32'(nibs[15:8]), 32'(8'(last_cnt + 8'h01)));
    check(32'(nibs[7:4]), 32'(4'(~f[11:8])));  // Inverse
    check(32'(nibs[3:0]), 32'(crc6(nibs[27:4])));  // CRC
    last_cnt = nibs[15:8];
  endtask
  // Reset values, refused accesses, short tick
  task automatic t_regs();
    check(32'({sleep, oe}), 32'h2);  // Asleep
    apb(1'b0, ADDR_CTRL, '0);
    check(rd, 32'h8);  // Pause off by default
    apb(1'b0, ADDR_TICK, '0);
    check(rd, 32'h64);  // Default tick
    apb(1'b0, 8'h10, '0);
    check({rd[30:0], e}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'hff);
    check(32'(e), 32'h1);
    apb(1'b1, ADDR_TICK, 32'h4);
  endtask
  // Value given in sync is sent; without a new one it is reused
  task automatic t_frame();
    slp <= 1'b0;
    wait_conv();  // Wake
    fld <= 12'h9c3;
    fv <= 1'b1;
    @(posedge clk);
    fv <= 1'b0;
    fld <= 12'h555;
    chk_frame(12'h9c3, ST_NORMAL, 1'b0);  // Sync sample
    chk_frame(12'h9c3, ST_NORMAL, 1'b1);  // Counter
    check(32'(len >= MSG_MIN_TK && len <= MSG_MAX_TK), 32'h1);
    apb(1'b0, ADDR_FIELD, '0);
    check(rd, 32'h9c3);  // Reported field
    err <= 1'b1;
    wait_frame();
    chk_frame(12'h9c3, ST_ERROR, 1'b0);  // Error
    err <= 1'b0;
  endtask
  // Range select and pause pulse
  task automatic t_cfg();
    apb(1'b1, ADDR_CTRL, 32'ha);
    @(posedge clk);
    check(32'(wide), 32'h1);  // Wide range
    apb(1'b1, ADDR_CTRL, 32'h9);
    @(posedge clk);
    check(32'(wide), 32'h0);  // Narrow range
    repeat (3) wait_frame();
    check(32'(len), 32'h100);  // Padded frame
    apb(1'b1, ADDR_CTRL, 32'h8);
  endtask
  // Self-test pin, polarity reversed on the second activation
  task automatic t_pin();
    logic [11:0] v;
    apb(1'b1, ADDR_CTRL, 32'hc);
    for (int k = 0; k < 2; k++) begin
      tst_n <= 1'b0;
      wait_frame();
      // Coil moves the field in the first test; the second restores it
      v = k ? 12'h9c3 : 12'hac3;
      fld <= v;
      fv <= 1'b1;
      @(posedge clk);
      fv <= 1'b0;
      chk_frame(v, k ? ST_COIL_SELF_TEST_NEG : ST_COIL_SELF_TEST_POS, 1'b0);
      check(32'({coil, neg}), 32'(2 + k));  // Coil on
      tst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check(32'(coil), 32'h0);  // Coil off
    end
    apb(1'b1, ADDR_CTRL, 32'h8);
  endtask
  // Line held low by the receiver starts sixteen test frames
  task automatic t_line();
    int         n;
    logic [1:0] s;
    hold <= 1'b1;
    repeat (300 * 4) @(posedge clk);
    hold <= 1'b0;
    for (n = 0; n < 200 && oe !== 1'b1; n++) @(posedge clk);
    check(32'(n >= 48 && n <= 58), 32'h1);  // Resume delay
    for (int k = 0; k < 16; k++) begin
      s = k < 8 ? ST_COIL_SELF_TEST_POS : ST_COIL_SELF_TEST_NEG;
      chk_frame(12'h9c3, s, k > 0);  // Test frames
      if (k == 4) check(32'({coil, neg}), 32'h2);  // Coil
    end
    chk_frame(12'h9c3, ST_NORMAL, 1'b1);  // Back to normal
  endtask
  // Main sequence
  initial begin
    {rstn, psel, pen, pwr, fv, err, hold} = '0;
    {tst_n, slp} = 2'h3;
    pa = '0;
    pwd = '0;
    fld = '0;
    last_cnt = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_frame();
    t_cfg();
    t_pin();
    t_line();
    check(32'(lowbad), 32'h0);  // Low pulses
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'({sleep, oe}), 32'h2);  // Abort to sleep
    slp <= 1'b0;
    wait_conv();  // Resume
    close_out();
  end
endmodule  // test_sft_top
